// ==== design/charger_defs.vh ====
`ifndef CHARGER_DEFS_VH
`define CHARGER_DEFS_VH

// Seven-bit bus address of the register bank.
`define SLAVE_ADDR         7'h6B

// Register offsets; the bank answers up to the last offset.
`define OFS_INPUT_SOURCE   8'h00
`define OFS_POWER_ON_CFG   8'h01
`define OFS_CHARGE_CURRENT 8'h02
`define OFS_SKIPPED        8'h09
`define OFS_LAST           8'h0B

// Power-on values.
`define POV_INPUT_SOURCE   8'h17
`define POV_POWER_ON_CFG   8'h1A
`define POV_CHARGE_CURRENT 8'hA2

// Fields that watchdog expiry returns to their power-on value.
`define WD_MASK_INPUT_SOURCE   8'h80
`define WD_MASK_POWER_ON_CFG   8'h70
`define WD_MASK_CHARGE_CURRENT 8'hBF

// Field positions.
`define BIT_DISCONNECT     7
`define BIT_STAT_MSB       6
`define BIT_STAT_LSB       5
`define BIT_ILIM_MSB       4
`define BIT_LIGHT_LOAD     7
`define BIT_WD_KICK        6
`define BIT_BOOST_EN       5
`define BIT_CHARGE_EN      4
`define BIT_SYSMIN_MSB     3
`define BIT_SYSMIN_LSB     1
`define BIT_LOW_BATT_SEL   0
`define BIT_BOOST_CURRENT_LIMIT      7
`define BIT_SWITCH_FULL_ON 6
`define BIT_FAST_CHARGE_CURRENT_MSB       5

// Field codes.
`define ILIM_CODE_SEL_HIGH 5'h04
`define ILIM_CODE_SEL_LOW  5'h17
`define ILIM_CODE_700MA    5'h06
`define FAST_CHARGE_CURRENT_CODE_MAX      6'h32
`define STAT_CODE_ENABLE   2'h0
`define STAT_CODE_FLOAT    2'h3

// Read answers outside the implemented registers.
`define READ_UNIMPL        8'h00
`define READ_UNMAPPED      8'hFF

`endif

// ==== design/bus_line_monitor.v ====
`include "charger_defs.vh"
`default_nettype none

// Finds clock edges and start/stop conditions on the two bus lines.
module bus_line_monitor (
  // Clock and reset.
  input  wire CLK,
  input  wire RST_N,
  // Bus lines, already synchronous.
  input  wire scl,
  input  wire sda,
  // Events, one cycle each.
  output wire start_p,
  output wire stop_p,
  output wire rise_p,
  output wire fall_p
);

  reg scl_q; // Line levels of the previous cycle.
  reg sda_q;

  // Idle bus is high, so the history starts high.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // A data change while the clock stays high is a condition, not a bit.
  assign start_p = scl & scl_q & sda_q & ~sda;
  assign stop_p  = scl & scl_q & ~sda_q & sda;
  assign rise_p  = scl & ~scl_q;
  assign fall_p  = ~scl & scl_q;

endmodule // bus_line_monitor
`default_nettype wire

// ==== design/charge_field_decoder.v ====
`include "charger_defs.vh"
`default_nettype none

// Turns the three stored bytes into registered control levels.
module charge_field_decoder (
  // Clock and reset.
  input  wire       CLK,
  input  wire       RST_N,
  // Stored bytes and the enable pin.
  input  wire [7:0] src_q,
  input  wire [7:0] cfg_q,
  input  wire [7:0] chg_q,
  input  wire       charge_enable_n_pin,
  // Decoded controls.
  output reg        charge_active,
  output reg        switch_full_on,
  output reg  [5:0] fast_charge_current,
  output reg        status_enable,
  output reg        status_float
);

  wire [5:0] fast_charge_current_raw; // Fast charge code as stored.
  wire       boost;    // Boost mode requested.

  assign fast_charge_current_raw = chg_q[`BIT_FAST_CHARGE_CURRENT_MSB:0];
  assign boost    = cfg_q[`BIT_BOOST_EN];

  // All controls follow the bytes one cycle later.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      charge_active       <= 1'b0;
      switch_full_on      <= 1'b0;
      fast_charge_current <= 6'h00;
      status_enable       <= 1'b0;
      status_float        <= 1'b0;
    end else begin
      // Boost wins; charging also needs the pin low and a nonzero code.
      charge_active <= cfg_q[`BIT_CHARGE_EN] & ~charge_enable_n_pin & ~boost & (fast_charge_current_raw != 6'h00);
      // Below 700mA the switch stays at high resistance unless forced on or in boost.
      switch_full_on <= boost | chg_q[`BIT_SWITCH_FULL_ON] |
                        (src_q[`BIT_ILIM_MSB:0] >= `ILIM_CODE_700MA);
      // Codes above fifty run at the maximum current.
      fast_charge_current <= (fast_charge_current_raw > `FAST_CHARGE_CURRENT_CODE_MAX) ? `FAST_CHARGE_CURRENT_CODE_MAX : fast_charge_current_raw;
      // Reserved codes neither run the pin nor float it.
      status_enable <= (src_q[`BIT_STAT_MSB:`BIT_STAT_LSB] == `STAT_CODE_ENABLE);
      status_float  <= (src_q[`BIT_STAT_MSB:`BIT_STAT_LSB] == `STAT_CODE_FLOAT);
    end
  end

endmodule // charge_field_decoder
`default_nettype wire

// ==== design/charger_control_register_bank.v ====
`include "charger_defs.vh"
`default_nettype none

module charger_control_register_bank (
  // Clock and reset.
  input  wire       CLK,
  input  wire       RST_N,
  // Serial bus; data is open drain.
  input  wire       SCL,
  input  wire       SDA_IN,
  output wire       SDA_OUT,
  output wire       SDA_OE,
  // Events from the rest of the charger.
  input  wire       REG_RESET,
  input  wire       WATCHDOG_EXPIRED,
  input  wire       WATCHDOG_RESTARTED,
  input  wire       SOURCE_DETECT_DONE,
  input  wire       SOURCE_SELECT_PIN,
  input  wire       CHARGE_ENABLE_N_PIN,
  // Input source controls.
  output wire       INPUT_DISCONNECT_EN,
  output wire       STATUS_PIN_ENABLE,
  output wire       STATUS_PIN_FLOAT,
  output wire [4:0] INPUT_CURRENT_LIMIT,
  // Power-on configuration controls.
  output wire       LIGHT_LOAD_MODULATION_DISABLE,
  output wire       WATCHDOG_KICK,
  output wire       REVERSE_BOOST_EN,
  output wire       CHARGE_ACTIVE,
  output wire [2:0] MIN_SYSTEM_VOLTAGE,
  output wire       BOOST_LOW_BATT_THRESHOLD_SEL,
  // Charge current controls.
  output wire       BOOST_CURRENT_LIMIT,
  output wire       INPUT_SWITCH_FULL_ON,
  output wire [5:0] FAST_CHARGE_CURRENT
);

  // Bus engine states.
  localparam [3:0] ST_IDLE      = 4'h0; // Not addressed.
  localparam [3:0] ST_ADDR      = 4'h1; // Taking the address byte.
  localparam [3:0] ST_ADDR_ACK  = 4'h2; // Acknowledging the address.
  localparam [3:0] ST_REG       = 4'h3; // Taking the register pointer.
  localparam [3:0] ST_REG_ACK   = 4'h4; // Acknowledging the pointer.
  localparam [3:0] ST_WDATA     = 4'h5; // Taking a data byte.
  localparam [3:0] ST_WDATA_ACK = 4'h6; // Acknowledging a data byte.
  localparam [3:0] ST_RDATA     = 4'h7; // Sending a data byte.
  localparam [3:0] ST_RACK      = 4'h8; // Waiting for the master's answer.
  localparam [3:0] ST_RNEXT     = 4'h9; // Master asked for another byte.

  // Stored registers, all eight bits wide.
  reg  [7:0] src_q; // Input source control.
  reg  [7:0] cfg_q; // Power-on configuration.
  reg  [7:0] chg_q; // Charge current control.

  // Bus engine state.
  reg  [3:0] state_q;   // Current state.
  reg  [3:0] bit_cnt_q; // Bits moved in the current byte.
  reg  [7:0] shift_q;   // Byte being moved.
  reg  [7:0] ptr_q;     // Register pointer.
  reg        sda_oe_q;  // Pulling data low.

  // Line events.
  wire       start_p;
  wire       stop_p;
  wire       rise_p;
  wire       fall_p;

  // Engine decisions.
  wire       byte_full; // Eight bits in hand.
  reg        ack_ok;    // The byte just taken is acknowledged.
  wire       wr_en;     // Store the byte just taken.
  wire [7:0] rd_byte;   // Byte the pointer reads.

  // Next pointer in a burst; the fault register is passed over.
  function [7:0] next_addr;
    input [7:0] addr;
    begin
      if (addr == `OFS_SKIPPED - 8'h01) begin
        next_addr = `OFS_SKIPPED + 8'h01;
      end else if (addr == 8'hFF) begin
        next_addr = addr;
      end else begin
        next_addr = addr + 8'h01;
      end
    end
  endfunction

  // Read decode; beyond the map the bank answers all ones.
  function [7:0] read_byte;
    input [7:0] addr;
    input [7:0] r0;
    input [7:0] r1;
    input [7:0] r2;
    begin
      case (addr)
        `OFS_INPUT_SOURCE: begin
          read_byte = r0;
        end
        `OFS_POWER_ON_CFG: begin
          read_byte = r1;
        end
        `OFS_CHARGE_CURRENT: begin
          read_byte = r2;
        end
        default: begin
          read_byte = (addr > `OFS_LAST) ? `READ_UNMAPPED : `READ_UNIMPL;
        end
      endcase
    end
  endfunction

  // Watchdog expiry puts the masked fields back, keeps the rest.
  function [7:0] wd_restore;
    input [7:0] cur;
    input [7:0] pov;
    input [7:0] mask;
    begin
      wd_restore = (cur & ~mask) | (pov & mask);
    end
  endfunction

  // Edges and conditions of the bus lines.
  bus_line_monitor u_monitor (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .scl     (SCL),
    .sda     (SDA_IN),
    .start_p (start_p),
    .stop_p  (stop_p),
    .rise_p  (rise_p),
    .fall_p  (fall_p)
  );

  assign byte_full = (bit_cnt_q == 4'h8);
  assign rd_byte   = read_byte(ptr_q, src_q, cfg_q, chg_q);

  // A data byte is stored at the clock fall that ends it.
  assign wr_en = (state_q == ST_WDATA) && fall_p && byte_full;

  // Decide whether the byte in hand earns an acknowledge.
  always @* begin
    case (state_q)
      ST_ADDR: begin
        ack_ok = (shift_q[7:1] == `SLAVE_ADDR);
      end
      ST_REG: begin
        // An undefined pointer is refused and the engine goes idle.
        ack_ok = (shift_q <= `OFS_LAST);
      end
      ST_WDATA: begin
        ack_ok = 1'b1;
      end
      default: begin
        ack_ok = 1'b0;
      end
    endcase
  end

  // Bus engine. Stop and start are honoured in any state, so a
  // master that gives up mid-byte never leaves the line pulled low.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      sda_oe_q  <= 1'b0;
    end else if (stop_p) begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_p) begin
      // A repeated start keeps the pointer for the read that follows.
      state_q   <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (rise_p && !byte_full) begin
            // Most significant bit arrives first.
            shift_q   <= {shift_q[6:0], SDA_IN};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (fall_p && byte_full) begin
            bit_cnt_q <= 4'h0;
            if (ack_ok) begin
              sda_oe_q <= 1'b1;
              state_q  <= state_q + 4'h1;
            end else begin
              state_q <= ST_IDLE;
            end
            if (state_q == ST_WDATA) begin
              ptr_q <= next_addr(ptr_q);
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall_p) begin
            if (shift_q[0]) begin
              // Read: put out the first bit at once.
              state_q  <= ST_RDATA;
              shift_q  <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
            end else begin
              state_q  <= ST_REG;
              sda_oe_q <= 1'b0;
            end
          end
        end
        ST_REG_ACK: begin
          if (fall_p) begin
            ptr_q    <= shift_q;
            sda_oe_q <= 1'b0;
            state_q  <= ST_WDATA;
          end
        end
        ST_WDATA_ACK: begin
          if (fall_p) begin
            sda_oe_q <= 1'b0;
            state_q  <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (rise_p) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (fall_p) begin
            if (byte_full) begin
              // Free the line for the master's answer.
              bit_cnt_q <= 4'h0;
              sda_oe_q  <= 1'b0;
              state_q   <= ST_RACK;
            end else begin
              shift_q  <= {shift_q[6:0], 1'b0};
              sda_oe_q <= ~shift_q[6];
            end
          end
        end
        ST_RACK: begin
          if (rise_p) begin
            if (SDA_IN) begin
              // No acknowledge: nothing more to send.
              state_q <= ST_IDLE;
            end else begin
              ptr_q   <= next_addr(ptr_q);
              state_q <= ST_RNEXT;
            end
          end
        end
        ST_RNEXT: begin
          if (fall_p) begin
            state_q  <= ST_RDATA;
            shift_q  <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
          end
        end
        default: begin
          // Idle and any stray code wait for the next start.
          state_q  <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Register store. The reset command outranks watchdog expiry, which
  // outranks a host write; a host write outranks the device's own updates.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      src_q <= `POV_INPUT_SOURCE;
      cfg_q <= `POV_POWER_ON_CFG;
      chg_q <= `POV_CHARGE_CURRENT;
    end else if (REG_RESET) begin
      src_q <= `POV_INPUT_SOURCE;
      cfg_q <= `POV_POWER_ON_CFG;
      chg_q <= `POV_CHARGE_CURRENT;
    end else if (WATCHDOG_EXPIRED) begin
      src_q <= wd_restore(src_q, `POV_INPUT_SOURCE, `WD_MASK_INPUT_SOURCE);
      cfg_q <= wd_restore(cfg_q, `POV_POWER_ON_CFG, `WD_MASK_POWER_ON_CFG);
      chg_q <= wd_restore(chg_q, `POV_CHARGE_CURRENT, `WD_MASK_CHARGE_CURRENT);
    end else begin
      // Input source control.
      if (wr_en && ptr_q == `OFS_INPUT_SOURCE) begin
        src_q <= shift_q;
      end else if (SOURCE_DETECT_DONE) begin
        // Detection picks the limit; the host may overwrite it later.
        src_q[`BIT_ILIM_MSB:0] <= SOURCE_SELECT_PIN ? `ILIM_CODE_SEL_HIGH : `ILIM_CODE_SEL_LOW;
      end
      // Power-on configuration; a host kick wins over the restart clear.
      if (wr_en && ptr_q == `OFS_POWER_ON_CFG) begin
        cfg_q <= shift_q;
      end else if (WATCHDOG_RESTARTED) begin
        cfg_q[`BIT_WD_KICK] <= 1'b0;
      end
      // Charge current control.
      if (wr_en && ptr_q == `OFS_CHARGE_CURRENT) begin
        chg_q <= shift_q;
      end
    end
  end

  // Derived controls that decode, clamp or combine the stored fields.
  charge_field_decoder u_decoder (
    .CLK                 (CLK),
    .RST_N               (RST_N),
    .src_q               (src_q),
    .cfg_q               (cfg_q),
    .chg_q               (chg_q),
    .charge_enable_n_pin (CHARGE_ENABLE_N_PIN),
    .charge_active       (CHARGE_ACTIVE),
    .switch_full_on      (INPUT_SWITCH_FULL_ON),
    .fast_charge_current (FAST_CHARGE_CURRENT),
    .status_enable       (STATUS_PIN_ENABLE),
    .status_float        (STATUS_PIN_FLOAT)
  );

  // Open drain: the data line is only ever pulled low.
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = sda_oe_q;

  // Plain fields leave straight from the stored bytes.
  assign INPUT_DISCONNECT_EN           = src_q[`BIT_DISCONNECT];
  assign INPUT_CURRENT_LIMIT           = src_q[`BIT_ILIM_MSB:0];
  assign LIGHT_LOAD_MODULATION_DISABLE = cfg_q[`BIT_LIGHT_LOAD];
  assign WATCHDOG_KICK                 = cfg_q[`BIT_WD_KICK];
  assign REVERSE_BOOST_EN              = cfg_q[`BIT_BOOST_EN];
  assign MIN_SYSTEM_VOLTAGE            = cfg_q[`BIT_SYSMIN_MSB:`BIT_SYSMIN_LSB];
  assign BOOST_LOW_BATT_THRESHOLD_SEL  = cfg_q[`BIT_LOW_BATT_SEL];
  assign BOOST_CURRENT_LIMIT           = chg_q[`BIT_BOOST_CURRENT_LIMIT];

endmodule // charger_control_register_bank
`default_nettype wire

// ==== dv/charger_bank_props.sv ====
`default_nettype none
// Timing checks on the control pins of the charger register bank.
module charger_bank_props (
  // Clock and reset.
  input wire logic       CLK,
  input wire logic       RST_N,
  // Bus clock and side events.
  input wire logic       SCL,
  input wire logic       REG_RESET,
  input wire logic       WATCHDOG_EXPIRED,
  input wire logic       WATCHDOG_RESTARTED,
  input wire logic       SOURCE_DETECT_DONE,
  input wire logic       SOURCE_SELECT_PIN,
  input wire logic       CHARGE_ENABLE_N_PIN,
  // Decoded controls.
  input wire logic       INPUT_DISCONNECT_EN,
  input wire logic [4:0] INPUT_CURRENT_LIMIT,
  input wire logic       LIGHT_LOAD_MODULATION_DISABLE,
  input wire logic       WATCHDOG_KICK,
  input wire logic       REVERSE_BOOST_EN,
  input wire logic       CHARGE_ACTIVE,
  input wire logic [2:0] MIN_SYSTEM_VOLTAGE,
  input wire logic       BOOST_LOW_BATT_THRESHOLD_SEL,
  input wire logic       BOOST_CURRENT_LIMIT,
  input wire logic       INPUT_SWITCH_FULL_ON,
  input wire logic [5:0] FAST_CHARGE_CURRENT
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clock and reset are stated once.
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  AST_POV_RELEASE: assert property (
    $rose(RST_N) |-> INPUT_CURRENT_LIMIT == 5'h17 && MIN_SYSTEM_VOLTAGE == 3'h5 && BOOST_CURRENT_LIMIT)
    else $error("controls not at power-on value after reset");
  AST_RESET_CMD: assert property (
    REG_RESET |=> INPUT_CURRENT_LIMIT == 5'h17 && MIN_SYSTEM_VOLTAGE == 3'h5 && !INPUT_DISCONNECT_EN
    && !LIGHT_LOAD_MODULATION_DISABLE && !BOOST_LOW_BATT_THRESHOLD_SEL && BOOST_CURRENT_LIMIT)
    else $error("register reset did not restore fields");
  AST_WD_EXPIRY: assert property (
    WATCHDOG_EXPIRED && !REG_RESET |=> !INPUT_DISCONNECT_EN && !WATCHDOG_KICK && !REVERSE_BOOST_EN
    && BOOST_CURRENT_LIMIT)
    else $error("watchdog expiry did not restore fields");
  // Host writes land only on edges with the bus clock low, so SCL high rules a clash out.
  AST_SRC_DETECT: assert property (
    SOURCE_DETECT_DONE && SCL && !REG_RESET && !WATCHDOG_EXPIRED
    |=> INPUT_CURRENT_LIMIT == ($past(SOURCE_SELECT_PIN) ? 5'h04 : 5'h17))
    else $error("detection loaded wrong input limit");
  AST_KICK_CLEAR: assert property (
    WATCHDOG_RESTARTED && SCL |=> !WATCHDOG_KICK)
    else $error("kick bit not cleared after restart");
  AST_FCC_CLAMP: assert property (
    FAST_CHARGE_CURRENT <= 6'h32)
    else $error("fast charge current above clamp");
  AST_CHARGE_PIN: assert property (
    CHARGE_ENABLE_N_PIN |=> !CHARGE_ACTIVE)
    else $error("charging while enable pin high");
  AST_BOOST_PRIORITY: assert property (
    REVERSE_BOOST_EN |=> !CHARGE_ACTIVE)
    else $error("charging while boost enabled");
  AST_ZERO_CURRENT: assert property (
    FAST_CHARGE_CURRENT == 6'h00 |-> !CHARGE_ACTIVE)
    else $error("charging with zero current code");
  AST_FULL_ON: assert property (
    INPUT_CURRENT_LIMIT >= 5'h06 || REVERSE_BOOST_EN |=> INPUT_SWITCH_FULL_ON)
    else $error("input switch not fully on");
endmodule // charger_bank_props

bind charger_control_register_bank charger_bank_props props_u (
  .CLK(CLK), .RST_N(RST_N), .SCL(SCL), .REG_RESET(REG_RESET), .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED),
  .WATCHDOG_RESTARTED(WATCHDOG_RESTARTED), .SOURCE_DETECT_DONE(SOURCE_DETECT_DONE),
  .SOURCE_SELECT_PIN(SOURCE_SELECT_PIN), .CHARGE_ENABLE_N_PIN(CHARGE_ENABLE_N_PIN),
  .INPUT_DISCONNECT_EN(INPUT_DISCONNECT_EN), .INPUT_CURRENT_LIMIT(INPUT_CURRENT_LIMIT),
  .LIGHT_LOAD_MODULATION_DISABLE(LIGHT_LOAD_MODULATION_DISABLE), .WATCHDOG_KICK(WATCHDOG_KICK),
  .REVERSE_BOOST_EN(REVERSE_BOOST_EN), .CHARGE_ACTIVE(CHARGE_ACTIVE), .MIN_SYSTEM_VOLTAGE(MIN_SYSTEM_VOLTAGE),
  .BOOST_LOW_BATT_THRESHOLD_SEL(BOOST_LOW_BATT_THRESHOLD_SEL), .BOOST_CURRENT_LIMIT(BOOST_CURRENT_LIMIT),
  .INPUT_SWITCH_FULL_ON(INPUT_SWITCH_FULL_ON), .FAST_CHARGE_CURRENT(FAST_CHARGE_CURRENT));
`default_nettype wire

// ==== dv/i2c_host_model.sv ====
`include "charger_defs.vh"
`default_nettype none
// Bus master standing in for the host processor.
module i2c_host_model (
  // Clock.
  input  wire logic CLK,
  // Bus lines; a released data line reads high through the pull-up.
  output var logic  scl,
  output var logic  sda_m,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero, so the device sees no false start.
  initial scl = 1'b1;
  initial sda_m = 1'b1;
  // Four clocks per level, twice the least the device needs.
  task automatic half();
    repeat (4) @(negedge CLK);
  endtask
  // Data moves only while the clock is low.
  task automatic put(input logic b);
    sda_m = b;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
  endtask
  // Sampled at the end of the high phase, when the device has settled.
  task automatic get(output logic b);
    sda_m = 1'b1;
    half();
    scl = 1'b1;
    half();
    b = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    sda_m = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b1;
    half();
  endtask
  // Sends a byte most significant bit first; ack is high if the line was pulled low.
  task automatic send(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put(v[i]);
    get(b);
    ack = ~b;
  endtask
  // Receives a byte; the last one is answered with a release.
  task automatic take(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) get(v[i]);
    put(last);
  endtask
  task automatic write_regs(input logic [6:0] adr, input logic [7:0] ptr, input int n,
                            input logic [7:0] d [3], output logic [1:0] acks);
    logic a;
    start();
    send({adr, 1'b0}, acks[0]);
    send(ptr, acks[1]);
    for (int i = 0; i < n; i++) send(d[i], a);
    stop();
  endtask
  task automatic read_regs(input logic [7:0] ptr, input int n, output logic [7:0] d [3], output logic ok);
    logic [2:0] a;
    start();
    send({`SLAVE_ADDR, 1'b0}, a[0]);
    send(ptr, a[1]);
    start();
    send({`SLAVE_ADDR, 1'b1}, a[2]);
    for (int i = 0; i < n; i++) take(d[i], i == n - 1);
    stop();
    ok = &a;
  endtask
endmodule // i2c_host_model
`default_nettype wire

// ==== dv/charger_control_register_bank_tb_top.sv ====
`include "charger_defs.vh"
`default_nettype none
// Drives the register bank through the bus model and checks readback and controls.
module charger_control_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Inputs, idle at time zero.
  logic CLK = 1'b0, RST_N = 1'b0, REG_RESET = 1'b0, WATCHDOG_EXPIRED = 1'b0, WATCHDOG_RESTARTED = 1'b0;
  logic SOURCE_DETECT_DONE = 1'b0, SOURCE_SELECT_PIN = 1'b0, CHARGE_ENABLE_N_PIN = 1'b0;
  wire logic        SCL, sda_m, SDA_IN, SDA_OUT, SDA_OE;
  wire logic [23:0] outs;
  logic      [7:0]  m [3];
  int num_errors = 0, checks_done = 0, cycles = 0, seed;
  // Open-drain line: the device's level counts only while it drives, so a wrong level spoils every ack.
  assign SDA_IN = sda_m & (SDA_OE ? SDA_OUT : 1'b1);
  always #12.5 CLK = ~CLK;
  i2c_host_model host_u (.CLK(CLK), .scl(SCL), .sda_m(sda_m), .sda(SDA_IN));
  charger_control_register_bank dut_u (
    .CLK(CLK), .RST_N(RST_N), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .REG_RESET(REG_RESET), .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED), .WATCHDOG_RESTARTED(WATCHDOG_RESTARTED),
    .SOURCE_DETECT_DONE(SOURCE_DETECT_DONE), .SOURCE_SELECT_PIN(SOURCE_SELECT_PIN),
    .CHARGE_ENABLE_N_PIN(CHARGE_ENABLE_N_PIN), .INPUT_DISCONNECT_EN(outs[23]),
    .STATUS_PIN_ENABLE(outs[22]), .STATUS_PIN_FLOAT(outs[21]), .INPUT_CURRENT_LIMIT(outs[20:16]),
    .LIGHT_LOAD_MODULATION_DISABLE(outs[15]), .WATCHDOG_KICK(outs[14]), .REVERSE_BOOST_EN(outs[13]),
    .CHARGE_ACTIVE(outs[12]), .MIN_SYSTEM_VOLTAGE(outs[11:9]), .BOOST_LOW_BATT_THRESHOLD_SEL(outs[8]),
    .BOOST_CURRENT_LIMIT(outs[7]), .INPUT_SWITCH_FULL_ON(outs[6]), .FAST_CHARGE_CURRENT(outs[5:0]));
  // Control pins expected from the three register values and the enable pin.
  function automatic logic [23:0] expect_outs(input logic [7:0] a, b, c, input logic n);
    logic [5:0] f;
    f = (c[5:0] > 6'h32) ? 6'h32 : c[5:0];
    return {a[7], a[6:5] == 2'h0, a[6:5] == 2'h3, a[4:0], b[7:5], b[4] & ~n & ~b[5] & (c[5:0] != 6'h00),
            b[3:0], c[7], b[5] | c[6] | (a[4:0] >= 5'h06), f};
  endfunction
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reads all three registers in one burst and checks them and every control pin.
  task automatic check_all();
    logic [7:0]  d [3];
    logic        ok;
    logic [23:0] e;
    host_u.read_regs(8'h00, 3, d, ok);
    chk("read ack", 24'(ok), 24'h1);
    for (int i = 0; i < 3; i++) chk("register", 24'(d[i]), 24'(m[i]));
    e = expect_outs(m[0], m[1], m[2], CHARGE_ENABLE_N_PIN);
    chk("controls", outs, e);
  endtask
  // Bytes past the third register are acknowledged but not kept.
  task automatic put_regs(input logic [7:0] ptr, input int n, input logic [7:0] d [3]);
    logic [1:0] a;
    host_u.write_regs(`SLAVE_ADDR, ptr, n, d, a);
    chk("write ack", 24'(a), 24'h3);
    for (int i = 0; i < n; i++) if (ptr + i < 3) m[ptr + i] = d[i];
  endtask
  // One-cycle side event, launched on a falling edge while the bus rests.
  task automatic pulse(ref logic s);
    @(negedge CLK);
    s = 1'b1;
    @(negedge CLK);
    s = 1'b0;
    repeat (2) @(negedge CLK);
  endtask
  // A hang counts as a mismatch; the limit is nearly four times the expected run.
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    logic [7:0] d [3];
    logic [1:0] a;
    logic [5:0] corner [4];
    seed = $urandom(32'h5b8f_c2e3);
    corner = '{6'h00, 6'h32, 6'h33, 6'h3F};
    m = '{8'h17, 8'h1A, 8'hA2};
    repeat (20) @(negedge CLK);
    RST_N = 1'b1;
    repeat (2) @(negedge CLK);
    check_all();
    // Random bursts; the first four force each status code and the current code edges.
    for (int i = 0; i < 8; i++) begin
      CHARGE_ENABLE_N_PIN = 1'($urandom);
      foreach (d[j]) d[j] = 8'($urandom);
      if (i < 4) begin
        d[0][6:5] = i[1:0];
        d[2][5:0] = corner[i];
      end
      put_regs((i < 4) ? 8'h00 : 8'h01, 3, d);
      check_all();
    end
    host_u.write_regs(7'h6A, 8'h00, 1, d, a);
    chk("foreign ack", 24'(a), 24'h0);
    // A pointer past the map is refused, so the data byte after it must not land anywhere.
    host_u.write_regs(`SLAVE_ADDR, 8'h0C, 1, d, a);
    chk("pointer ack", 24'(a), 24'h1);
    d[0] = m[1] | 8'h40;
    put_regs(8'h01, 1, d);
    chk("kick", 24'(outs[14]), 24'h1);
    pulse(WATCHDOG_RESTARTED);
    m[1][6] = 1'b0;
    check_all();
    for (int s = 0; s < 2; s++) begin
      SOURCE_SELECT_PIN = s[0];
      pulse(SOURCE_DETECT_DONE);
      m[0][4:0] = s[0] ? 5'h04 : 5'h17;
      check_all();
    end
    d = '{8'hFF, 8'hFF, 8'hFF};
    put_regs(8'h00, 3, d);
    pulse(WATCHDOG_EXPIRED);
    m[0][7] = 1'b0;
    m[1][6:4] = 3'h1;
    m[2] = {1'b1, m[2][6], 6'h22};
    check_all();
    pulse(REG_RESET);
    m = '{8'h17, 8'h1A, 8'hA2};
    check_all();
    complete_run();
  end
endmodule // charger_control_register_bank_tb_top
`default_nettype wire
